// [rtl/ccd_adc_output_timing_clamp.v]
// converter output pipeline, optical-black averaging and register slave
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ns
`include "ccd_clamp_defs.vh"
module ccd_adc_output_timing_clamp #(
  parameter DW = 10
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire [DW-1:0] sample_in,
  input  wire          optical_black_pulse,
  input  wire          preblank_input,
  input  wire          black_sample_strobe,
  input  wire          signal_sample_strobe,
  output reg  [DW-1:0] output_bus,
  output reg           output_valid,
  input  wire          output_ready,
  output reg  [3:0]    black_hold_tc_select,
  output reg  [1:0]    hold_bw_select,
  output reg           low_power_select,
  input  wire [3:0]    s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [3:0]    s_axi_araddr,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready
);
  localparam PIPE = 10;

  // pin synchronisers
  reg  [DW-1:0] smp_s1_r, smp_s2_r;
  reg  [1:0]    obp_s_r, pbk_s_r, sbk_s_r, ssg_s_r;
  reg           obp_d_r;
  // sample one stage behind the synchroniser, level with the pulse's edge detector
  reg  [DW-1:0] smp_d_r;
  // registers
  reg  [31:0]   ctrl_r;
  reg  [DW-1:0] clamp_r;
  reg  [DW-1:0] ob_avg_r;
  reg           ob_done_r;
  // window
  reg  [3:0]    ob_cnt_r;
  reg           ob_act_r;
  reg  [DW+2:0] ob_acc_r;
  // pipeline
  reg  [DW-1:0] pipe_r [0:PIPE-1];
  reg  [PIPE-1:0] pv_r;
  // axi
  reg  [3:0]    aw_r;
  reg  [31:0]   wd_r;
  reg  [3:0]    ws_r;
  reg           aw_ok_r, w_ok_r;

  wire          direct_mode = ctrl_r[`CTRL_PATH_BIT];
  wire          strobe_inv  = ctrl_r[`CTRL_INV_BIT];
  wire          pbk_act     = pbk_s_r[1] ^ strobe_inv;
  wire          sig_low     = ssg_s_r[1] ^ strobe_inv;  // low-going unless inverted
  wire          obp_rise    = obp_s_r[1] & ~obp_d_r;
  // the tap leaves room for the fifo stage and the output register, so that the
  // sampling register to the output register spans ten or nine cycles; the two
  // synchroniser flops in front add a fixed two cycles in both modes
  wire [DW-1:0] tap         = direct_mode ? pipe_r[`LAT_DIRECT-3] : pipe_r[`LAT_CORR-3];
  wire          tap_v       = direct_mode ? pv_r[`LAT_DIRECT-3] : pv_r[`LAT_CORR-3];
  wire          fifo_in_rdy;
  wire [DW-1:0] fifo_dout;
  wire          fifo_vld;
  wire          fifo_pop    = fifo_vld & (~output_valid | output_ready);
  wire [DW-1:0] wr_clamp    = wd_r[DW-1:0];
  // running sum plus the current sample; eight samples need three extra bits
  wire [DW+2:0] ob_sum      = ob_acc_r + {3'b000, smp_d_r};

  // two-stage synchronisers on the sample, pulse, preblank and strobe inputs; output_ready is used unsynchronised
  always @(posedge aclk) begin
    if (!aresetn) begin
      smp_s1_r <= {DW{1'b0}};
      smp_s2_r <= {DW{1'b0}};
      obp_s_r  <= 2'b00;
      pbk_s_r  <= 2'b00;
      sbk_s_r  <= 2'b00;
      ssg_s_r  <= 2'b00;
      obp_d_r  <= 1'b0;
      smp_d_r  <= {DW{1'b0}};
    end else begin
      smp_s1_r <= sample_in;                 // taken at the rising edge
      smp_s2_r <= smp_s1_r;
      obp_s_r  <= {obp_s_r[0], optical_black_pulse};
      pbk_s_r  <= {pbk_s_r[0], preblank_input};
      sbk_s_r  <= {sbk_s_r[0], black_sample_strobe};
      ssg_s_r  <= {ssg_s_r[0], signal_sample_strobe};
      obp_d_r  <= obp_s_r[1];
      smp_d_r  <= smp_s2_r;                  // stays level with obp_d_r, one cycle behind obp_rise
    end
  end

  // conversion pipeline, one stage per clock; the tap moves with the mode
  // a full fifo freezes every stage at once; new pin samples are dropped at the head
  genvar g;
  generate
    for (g = 0; g < PIPE; g = g + 1) begin : stage
      always @(posedge aclk) begin
        if (!aresetn) begin
          pipe_r[g] <= {DW{1'b0}};
          pv_r[g]   <= 1'b0;
        end else if (fifo_in_rdy) begin
          pipe_r[g] <= (g == 0) ? smp_s2_r : pipe_r[(g == 0) ? 0 : g-1];
          pv_r[g]   <= (g == 0) ? 1'b1 : pv_r[(g == 0) ? 0 : g-1];
        end
      end
    end
  endgenerate

  // optical-black window: edge after the pulse is cycle one, average cycles 5..12
  always @(posedge aclk) begin
    if (!aresetn) begin
      ob_cnt_r  <= 4'd0;
      ob_act_r  <= 1'b0;
      ob_acc_r  <= {(DW+3){1'b0}};
      ob_avg_r  <= `CLAMP_RESET;
      ob_done_r <= 1'b0;
    end else if (obp_rise) begin
      ob_cnt_r <= 4'd1;
      ob_act_r <= 1'b1;
      ob_acc_r <= {(DW+3){1'b0}};
    end else if (ob_act_r) begin
      ob_cnt_r <= ob_cnt_r + 4'd1;
      // the counter names the cycle whose sample sits in smp_d_r at this edge
      if (ob_cnt_r >= `OB_FIRST && ob_cnt_r <= `OB_LAST)
        ob_acc_r <= ob_sum;
      if (ob_cnt_r == `OB_LAST) begin
        ob_act_r  <= 1'b0;
        // dropping the low bits divides by eight; the remainder is discarded, not rounded
        ob_avg_r  <= ob_sum[DW+2:`OB_AVG_SHIFT];                 // mean of 8
        ob_done_r <= 1'b1;
      end
    end
  end

  // four words of slack let a short stall of the sink pass without losing samples
  sample_fifo #(
    .WIDTH (DW),
    .DEPTH (4),
    .AW    (2)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_data   (tap),
    .in_valid  (tap_v),
    .in_ready  (fifo_in_rdy),
    .out_data  (fifo_dout),
    .out_valid (fifo_vld),
    .out_ready (fifo_pop)
  );

  // output register: rising edge only, clamp code replaces data under preblank
  // the clamp code is chosen as each word leaves, two cycles after the pin moves
  always @(posedge aclk) begin
    if (!aresetn) begin
      output_bus   <= {DW{1'b0}};
      output_valid <= 1'b0;
    end else if (fifo_pop) begin
      output_bus   <= pbk_act ? clamp_r : fifo_dout;
      output_valid <= 1'b1;
    end else if (output_ready) begin
      output_valid <= 1'b0;
    end
  end

  // axi4-lite write: address and data taken in either order, response after both
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_ok_r <= 1'b0;
      w_ok_r  <= 1'b0;
      aw_r    <= 4'h0;
      wd_r    <= 32'h0;
      ws_r    <= 4'h0;
      ctrl_r  <= `CTRL_RESET;
      clamp_r <= `CLAMP_RESET;
      black_hold_tc_select <= 4'h0;
      hold_bw_select       <= 2'b01;
      low_power_select     <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_r <= s_axi_awaddr;
        aw_ok_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd_r <= s_axi_wdata;
        ws_r <= s_axi_wstrb;
        w_ok_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_ok_r && w_ok_r && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        if (aw_r == `ADDR_CTRL) begin
          if (ws_r[0])
            ctrl_r[7:0] <= wd_r[7:0];
          if (ws_r[1])
            ctrl_r[15:8] <= wd_r[15:8];
        end else if (aw_r == `ADDR_CLAMP) begin
          // out-of-range clamp codes are pinned to the legal span
          if (ws_r[0] && ws_r[1])
            clamp_r <= (wr_clamp < `CLAMP_MIN) ? `CLAMP_MIN :
                       (wr_clamp > `CLAMP_MAX) ? `CLAMP_MAX : wr_clamp;
        end else if (aw_r != `ADDR_STATUS && aw_r != `ADDR_OB_AVG) begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_ok_r       <= 1'b0;
        w_ok_r        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      // the field copies follow the control register one cycle later
      black_hold_tc_select <= ctrl_r[`CTRL_TC_LSB+3:`CTRL_TC_LSB];
      // code zero is forbidden; hardware keeps the last legal code
      if (ctrl_r[`CTRL_BW_LSB+1:`CTRL_BW_LSB] != 2'b00)
        hold_bw_select <= ctrl_r[`CTRL_BW_LSB+1:`CTRL_BW_LSB];
      low_power_select <= ctrl_r[`CTRL_LOW_POWER_SELECT_BIT];
    end
  end

  // axi4-lite read: one cycle to rvalid, held until rready
  // status is captured as the address is taken, not when rvalid is seen
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `RESP_OKAY;
      case (s_axi_araddr)
        `ADDR_CTRL:   s_axi_rdata <= {16'h0, ctrl_r[15:0]};
        `ADDR_CLAMP:  s_axi_rdata <= {22'h0, clamp_r};
        `ADDR_STATUS: s_axi_rdata <= {25'h0, sbk_s_r[1], sig_low, pbk_act,
                                     ob_act_r, ob_done_r, ~fifo_in_rdy, fifo_vld};
        `ADDR_OB_AVG: s_axi_rdata <= {22'h0, ob_avg_r};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // ccd_adc_output_timing_clamp

// [common/ccd_clamp_defs.vh]
// constants for the converter output timing and clamp block
`ifndef CCD_CLAMP_DEFS_VH
`define CCD_CLAMP_DEFS_VH
`define LAT_CORR        4'd10
`define LAT_DIRECT      4'd9
`define OB_FIRST        4'd5
`define OB_LAST         4'd12
`define OB_AVG_SHIFT    3
`define CLAMP_MIN       10'd14
`define CLAMP_MAX       10'd76
`define CLAMP_RESET     10'd14
`define ADDR_CTRL       4'h0
`define ADDR_CLAMP      4'h4
`define ADDR_STATUS     4'h8
`define ADDR_OB_AVG     4'hc
`define CTRL_PATH_BIT   0
`define CTRL_TC_LSB     4
`define CTRL_BW_LSB     8
`define CTRL_LOW_POWER_SELECT_BIT  10
`define CTRL_INV_BIT    11
`define CTRL_RESET      32'h0000_0100
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`endif

// [rtl/sample_fifo.v]
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
module sample_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wp_r;
  reg [AW-1:0]    rp_r;
  reg [AW:0]      cnt_r;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_r != DEPTH);
  assign out_valid = (cnt_r != 0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointers and occupancy; a full fifo refuses, so nothing is overwritten
  always @(posedge aclk) begin
    if (!aresetn) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_data;
        wp_r        <= wp_r + 1'b1;
      end
      if (pop)
        rp_r <= rp_r + 1'b1;
      if (push & ~pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop & ~push)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule // sample_fifo

// [testbench/ccd_clamp_chk.sv]
// checker for output timing, clamp code and register handshakes
`timescale 1ns/1ns
module ccd_clamp_chk (
  input wire        aclk,
  input wire        aresetn,
  input wire [9:0]  sample_in,
  input wire        preblank_input,
  input wire [9:0]  output_bus,
  input wire        output_valid,
  input wire        output_ready,
  input wire [1:0]  hold_bw_select,
  input wire [3:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready
);
  reg [3:0]  a_r;
  reg [31:0] d_r;
  reg        dir_r;
  reg [9:0]  cl_r;
  reg [9:0]  neg_r;
  reg [4:0]  calm_r;
  reg [4:0]  pb_r;
  reg        inv_r;
  wire       wr_done = s_axi_bvalid && s_axi_bready;
  wire       blank = preblank_input ^ inv_r;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // value seen mid-cycle, so a change after the falling edge is caught
  always @(negedge aclk) neg_r <= output_bus;
  // shadow of path and clamp; calm counts cycles with a steady stream
  always @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) a_r <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) d_r <= s_axi_wdata;
    if (!aresetn) {dir_r, inv_r} <= 2'b00;
    else if (wr_done && a_r == 4'h0) {dir_r, inv_r} <= {d_r[0], d_r[11]};
    if (!aresetn) cl_r <= 10'h00e;
    else if (wr_done && a_r == 4'h4)
      cl_r <= d_r < 32'd14 ? 10'h00e : d_r > 32'd76 ? 10'h04c : d_r[9:0];
    if (!aresetn || !output_ready || blank || (wr_done && a_r == 4'h0)) calm_r <= 5'h00;
    else if (calm_r != 5'h1f) calm_r <= calm_r + 5'h01;
    if (!aresetn || !blank || (wr_done && a_r == 4'h0)) pb_r <= 5'h00;
    else if (pb_r != 5'h10) pb_r <= pb_r + 5'h01;
  end
  chk_bus_edge_only: assert property (output_bus == neg_r)
    else $error("output bus moved after the falling edge");
  chk_corr_latency: assert property (calm_r == 5'h1f && !dir_r |-> output_bus == $past(sample_in, 12))
    else $error("correlated mode latency wrong");
  chk_direct_latency: assert property (calm_r == 5'h1f && dir_r |-> output_bus == $past(sample_in, 11))
    else $error("direct mode latency wrong");
  chk_bw_never_zero: assert property (hold_bw_select != 2'b00)
    else $error("bandwidth code all low");
  chk_blank_clamp: assert property (pb_r == 5'h10 |-> output_bus == cl_r)
    else $error("preblank output not the clamp code");
  chk_out_hold: assert property (output_valid && !output_ready |=> output_valid && $stable(output_bus))
    else $error("output dropped while stalled");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  cover property (calm_r == 5'h1f && dir_r);
  cover property (pb_r == 5'h10);
  cover property (pb_r == 5'h10 && inv_r);
  cover property (output_valid && !output_ready);
endmodule // ccd_clamp_chk

bind ccd_adc_output_timing_clamp ccd_clamp_chk chk (.*);

// [testbench/ccd_far_model.sv]
// far-side model: timing generator and output sink
`timescale 1ns/1ns
module ccd_far_model (
  input  wire       aclk,
  input  wire       stall,
  input  wire       ob_go,
  input  wire [9:0] ob_val,
  output wire [9:0] sample_in,
  output wire       optical_black_pulse,
  output reg        black_sample_strobe,
  output reg        signal_sample_strobe,
  output wire       output_ready
);
  reg [9:0] cnt_r = 10'h000;
  reg [4:0] k_r = 5'h00;
  // k counts edges of a black frame, edge of the pulse is one
  always @(posedge aclk) begin
    cnt_r <= cnt_r + 10'h001;
    if (ob_go) k_r <= 5'h01;
    else if (k_r != 5'h00 && k_r != 5'h14) k_r <= k_r + 5'h01;
    else k_r <= 5'h00;
  end
  assign optical_black_pulse = k_r == 5'h01 || k_r == 5'h02;
  // window cycles alternate by two so only an eight-sample mean lands on val+1
  assign sample_in = k_r == 5'h00 ? cnt_r : (k_r > 5'h04 && k_r < 5'h0d) ?
    ob_val + {k_r[0], 1'b0} : 10'h3ff;
  // low-going strobes of about a quarter period, idle high
  initial {black_sample_strobe, signal_sample_strobe} = 2'b11;
  always @(posedge aclk) begin
    #5 black_sample_strobe = 1'b0;
    #12 black_sample_strobe = 1'b1;
    #8 signal_sample_strobe = 1'b0;
    #12 signal_sample_strobe = 1'b1;
  end
  assign output_ready = !stall;
endmodule // ccd_far_model

// [testbench/testbench.sv]
// self-checking bench for the converter output timing and clamp block
`timescale 1ns/1ns
module testbench;
  logic        aclk, aresetn, preblank_input, stall, ob_go, low_power_select;
  logic [9:0]  sample_in, output_bus, ob_val, clamp;
  logic        optical_black_pulse, black_sample_strobe, signal_sample_strobe;
  logic        output_valid, output_ready, s_axi_awvalid, s_axi_awready;
  logic [3:0]  black_hold_tc_select, s_axi_awaddr, s_axi_araddr, tc;
  logic [1:0]  hold_bw_select, bw, s_axi_bresp, s_axi_rresp;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [65:0] q[$];
  logic [65:0] x;
  wire  [3:0]  s_axi_wstrb = 4'hf;
  int          fails = 0, check_count = 0, cyc = 0;
  ccd_adc_output_timing_clamp dut (.*);
  ccd_far_model far (.*);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic end_of_test;
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // write: response must be okay
  task automatic wr(logic [3:0] a, logic [31:0] d);
    q.push_back(66'h0);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do @(posedge aclk); while (!s_axi_awready);
    s_axi_awvalid <= 1'b0;
    while (!s_axi_wready) @(posedge aclk);
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e, logic [31:0] m, logic [1:0] r);
    q.push_back({r, m, e});
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // each response is matched against the oldest note
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      x = q.pop_front();
      chk("bresp", 32'(s_axi_bresp), 32'(x[65:64]));
    end
    if (s_axi_rvalid && s_axi_rready) begin
      x = q.pop_front();
      chk("rresp", 32'(s_axi_rresp), 32'(x[65:64]));
      chk("rdata", s_axi_rdata & x[63:32], x[31:0]);
    end
  end
  // a hang counts as a mismatch
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      end_of_test;
    end
  end
  initial begin
    void'($urandom(32'h98606607));
    {aresetn, preblank_input, stall, ob_go, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ob_val} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(4'h0, 32'h100, '1, 2'b00);
    rd(4'h4, 32'h00e, '1, 2'b00);
    rd(4'hc, 32'h00e, '1, 2'b00);
    chk("tc", 32'(black_hold_tc_select), 32'h0);
    // every bandwidth code; the all-low one keeps the last legal code
    bw = 2'b01;
    for (int i = 0; i < 4; i++) begin
      tc = 4'($urandom);
      if (2'(i + 1) != 2'b00) bw = 2'(i + 1);
      wr(4'h0, {21'h0, i[0], 2'(i + 1), tc, 4'h0});
      chk("tc", 32'(black_hold_tc_select), 32'(tc));
      chk("bw", 32'(hold_bw_select), 32'(bw));
      chk("low_power_select", 32'(low_power_select), 32'(i[0]));
    end
    // latency is watched by the checker in both modes
    repeat (40) @(posedge aclk);
    wr(4'h0, {22'h1, bw, tc, 4'h1});
    rd(4'h0, {22'h1, bw, tc, 4'h1}, '1, 2'b00);
    repeat (40) @(posedge aclk);
    // clamp code below, above and inside its range
    for (int i = 0; i < 3; i++) begin
      clamp = i == 0 ? 10'h005 : i == 1 ? 10'h064 : 10'(14 + $urandom % 63);
      wr(4'h4, 32'(clamp));
      clamp = clamp < 14 ? 10'h00e : clamp > 76 ? 10'h04c : clamp;
      rd(4'h4, 32'(clamp), '1, 2'b00);
    end
    preblank_input <= 1'b1;
    repeat (20) @(posedge aclk);
    chk("blank", 32'(output_bus), 32'(clamp));
    preblank_input <= 1'b0;
    // inverted polarity: a low preblank pin now forces the clamp code
    wr(4'h0, {20'h0, 2'b11, bw, tc, 4'h1});
    repeat (20) @(posedge aclk);
    chk("blank_inv", 32'(output_bus), 32'(clamp));
    wr(4'h0, {22'h1, bw, tc, 4'h1});
    ob_val <= 10'($urandom % 1000);
    ob_go <= 1'b1;
    @(posedge aclk);
    ob_go <= 1'b0;
    repeat (30) @(posedge aclk);
    rd(4'hc, 32'(ob_val) + 1, '1, 2'b00);
    rd(4'h8, 32'h4, 32'h4, 2'b00);
    rd(4'h2, 32'h0, '1, 2'b10);
    wr(4'h8, '1);
    // stall the sink until the fifo refuses
    stall <= 1'b1;
    repeat (20) @(posedge aclk);
    rd(4'h8, 32'h3, 32'h3, 2'b00);
    stall <= 1'b0;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(4'h0, 32'h100, '1, 2'b00);
    end_of_test;
  end
endmodule // testbench
